/* File: shrp_cfg.svh */
`ifndef SHRP_CFG_SVH
`define SHRP_CFG_SVH

// ==========================================================
// host wait intervals, in master clock cycles
`define SHRP_FM_WAIT_CYC 7'h38
`define SHRP_PCM_WAIT_CYC 7'h58

// ==========================================================
// status byte bit positions
`define SHRP_ST_IRQ_BIT 7
`define SHRP_ST_T1_BIT 6
`define SHRP_ST_T2_BIT 5
`define SHRP_ST_LD_BIT 1
`define SHRP_ST_BUSY_BIT 0

// ==========================================================
// location of the extension enable bit in fm array 1
`define SHRP_EXT_EN_INDEX 8'h05
`define SHRP_EXT_EN_BIT 0

// ==========================================================
// reset values
`define SHRP_BYTE_RST 8'h00

`endif

/* File: shrp_host_model.sv */
`timescale 1ns/1ps

// ==========================================================
// host cpu bus controller model
module shrp_host_model (
  // clock
  input wire logic ref_clk,
  // host strobes, address and data
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic host_addr_bit0,
  output logic fm_array_select,
  output logic pcm_space_select,
  output logic [7:0] data_in,
  // device drive of the bus
  input wire logic [7:0] data_out,
  input wire logic data_oe
);
  logic [7:0] last_ff = 8'h00; // last value the device drove

  // idle bus at time zero
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    {pcm_space_select, fm_array_select, host_addr_bit0} = 3'h0;
    data_in = 8'h00;
  end

  // floating bus shows the inverse of what was last driven
  always @(posedge ref_clk) begin
    if (data_oe) last_ff <= data_out;
  end

  // write cycle, then the host wait
  task automatic wr(input logic [2:0] a, input logic [7:0] d, input int gap);
    @(posedge ref_clk);
    cs_n <= 1'b0;
    wr_n <= 1'b0;
    {pcm_space_select, fm_array_select, host_addr_bit0} <= a;
    data_in <= d;
    repeat (2) @(posedge ref_clk);
    wr_n <= 1'b1;
    @(posedge ref_clk);
    cs_n <= 1'b1;
    data_in <= ~d;
    repeat (gap) @(posedge ref_clk);
  endtask

  // read cycle, sampled while the answer is settled
  task automatic rd(input logic [2:0] a, output logic [7:0] d, output logic oe);
    @(posedge ref_clk);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    {pcm_space_select, fm_array_select, host_addr_bit0} <= a;
    @(posedge ref_clk);
    @(negedge ref_clk);
    d = data_oe ? data_out : ~last_ff;
    oe = data_oe;
    @(posedge ref_clk);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
  endtask
endmodule

/* File: shrp_host_port.sv */
`timescale 1ns/1ps
`include "shrp_cfg.svh"
// What this block does
// - eight-bit data bus, three address bits, active-low strobes
// - deselected: bus released, strobes and address ignored
// - read at address zero drives status byte
// - address write latches fm index, a1 picks array
// - fm data write goes to last index
// - pcm address write latches pcm index
// - pcm data write stores into indexed register
// - pcm data read returns indexed register
// - fm registers have no read path
// - master clock in, half rate clock out
// - status: irq, timer flags, loading, busy
// - busy shown only once extension enabled
// - pcm space locked until extension enabled
module shrp_host_port (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // host strobes and address
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic host_addr_bit0,
  input wire logic fm_array_select,
  input wire logic pcm_space_select,
  // host data bus, split into three signals
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  // status flags from the synthesis core
  input wire logic irq_flag,
  input wire logic timer_one_flag,
  input wire logic timer_two_flag,
  input wire logic header_loading_flag,
  // fm register write towards the core
  output logic fm_wr_stb,
  output logic fm_wr_array,
  output logic [7:0] fm_wr_index,
  output logic [7:0] fm_wr_data,
  // pcm register write towards the core
  output logic pcm_wr_stb,
  output logic [7:0] pcm_wr_index,
  output logic [7:0] pcm_wr_data,
  // mode and timing status
  output logic extension_enable_bit,
  output logic write_busy,
  output logic half_rate_clock_out
);
  // ==========================================================
  // declarations
  logic rst_meta_ff; // reset release stage one
  logic rst_sync_ff; // reset release stage two
  logic rst_n; // internal reset
  logic wr_n_q_ff; // previous write strobe level
  logic cap_valid_ff; // a selected write strobe is active
  logic [2:0] cap_addr_ff; // address captured during strobe
  logic [7:0] cap_data_ff; // data captured during strobe
  logic wr_done; // rising edge of a selected write
  shrp_pkg::shrp_acc_t wr_kind; // decoded kind of finished write
  logic fm_array_ff; // array picked by last fm address write
  logic [7:0] fm_index_ff; // last fm index
  logic [7:0] fm_data_ff; // last fm data
  logic fm_stb_ff; // fm write pulse
  logic [7:0] pcm_index_ff; // last pcm index
  logic [7:0] pcm_data_ff; // last pcm data
  logic pcm_stb_ff; // pcm write pulse
  logic ext_en_ff; // extension enable
  shrp_pkg::shrp_state_t state_ff; // write interval state
  shrp_pkg::shrp_state_t nxt_state;
  logic [6:0] wait_cnt_ff; // cycles left in interval
  logic [6:0] nxt_wait_cnt;
  logic [7:0] status_byte; // assembled status
  logic [7:0] pcm_rd_data; // registered read from store
  logic [7:0] data_out_ff; // bus drive value
  logic data_oe_ff; // bus drive enable
  logic clk_div_ff; // half rate divider
  logic rd_status; // status read cycle decoded
  logic rd_pcm; // pcm read cycle decoded
  // ==========================================================
  // decode of an address into a cycle kind
  function automatic shrp_pkg::shrp_acc_t shrp_decode(input logic [2:0] a, input logic ext_en);
    shrp_pkg::shrp_acc_t k;
    k = shrp_pkg::SHRP_ACC_NONE;
    if (!a[2] && !a[0]) begin
      k = shrp_pkg::SHRP_ACC_FM_ADDR;
    end else if (!a[2] && a[0]) begin
      k = shrp_pkg::SHRP_ACC_FM_DATA; // a1 is a don't care here
    end else if (ext_en && !a[1] && !a[0]) begin
      k = shrp_pkg::SHRP_ACC_PCM_ADDR;
    end else if (ext_en && !a[1] && a[0]) begin
      k = shrp_pkg::SHRP_ACC_PCM_DATA;
    end
    return k;
  endfunction
  // ==========================================================
  // reset release through two flops
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  assign rst_n = rst_sync_ff;
  // ==========================================================
  // half rate clock for external use
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_div_ff <= 1'b0;
    end else begin
      clk_div_ff <= ~clk_div_ff;
    end
  end
  // ==========================================================
  // write strobe capture, address and data sampled every cycle while strobe low
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_n_q_ff <= 1'b1;
      cap_valid_ff <= 1'b0;
      cap_addr_ff <= 3'h0;
      cap_data_ff <= `SHRP_BYTE_RST;
    end else begin
      wr_n_q_ff <= wr_n;
      if (!cs_n && !wr_n && rd_n) begin
        cap_valid_ff <= 1'b1;
        cap_addr_ff <= {pcm_space_select, fm_array_select, host_addr_bit0};
        cap_data_ff <= data_in;
      end else if (wr_n || cs_n) begin
        cap_valid_ff <= 1'b0; // deselect abandons the cycle
      end
    end
  end
  // the write takes effect when the strobe goes high again
  assign wr_done = cap_valid_ff && !wr_n_q_ff && wr_n;
  assign wr_kind = wr_done ? shrp_decode(cap_addr_ff, ext_en_ff) : shrp_pkg::SHRP_ACC_NONE;
  // ==========================================================
  // fm index and data writes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fm_array_ff <= 1'b0;
      fm_index_ff <= `SHRP_BYTE_RST;
      fm_data_ff <= `SHRP_BYTE_RST;
      fm_stb_ff <= 1'b0;
    end else begin
      fm_stb_ff <= 1'b0;
      case (wr_kind)
        shrp_pkg::SHRP_ACC_FM_ADDR: begin
          fm_array_ff <= cap_addr_ff[1];
          fm_index_ff <= cap_data_ff;
        end
        shrp_pkg::SHRP_ACC_FM_DATA: begin
          fm_data_ff <= cap_data_ff;
          fm_stb_ff <= 1'b1;
        end
        default: begin
        end
      endcase
    end
  end
  // ==========================================================
  // extension enable, tracked from fm array 1 writes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_en_ff <= 1'b0;
    end else if (wr_kind == shrp_pkg::SHRP_ACC_FM_DATA && fm_array_ff
                 && fm_index_ff == `SHRP_EXT_EN_INDEX) begin
      ext_en_ff <= cap_data_ff[`SHRP_EXT_EN_BIT];
    end
  end
  // ==========================================================
  // pcm index and data writes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pcm_index_ff <= `SHRP_BYTE_RST;
      pcm_data_ff <= `SHRP_BYTE_RST;
      pcm_stb_ff <= 1'b0;
    end else begin
      pcm_stb_ff <= 1'b0;
      case (wr_kind)
        shrp_pkg::SHRP_ACC_PCM_ADDR: begin
          pcm_index_ff <= cap_data_ff;
        end
        shrp_pkg::SHRP_ACC_PCM_DATA: begin
          pcm_data_ff <= cap_data_ff;
          pcm_stb_ff <= 1'b1;
        end
        default: begin
        end
      endcase
    end
  end
  // pcm register store, written on the same edge as the pulse
  shrp_pcm_regs #(
    .AW(8),
    .DW(8)
  ) u_pcm_regs (
    .clk(ref_clk),
    .rst_n(rst_n),
    .wr_en(wr_kind == shrp_pkg::SHRP_ACC_PCM_DATA),
    .wr_addr(pcm_index_ff),
    .wr_data(cap_data_ff),
    .rd_addr(pcm_index_ff),
    .rd_data(pcm_rd_data)
  );
  // ==========================================================
  // write interval: busy for the host wait after each write decoded while idle
  always_comb begin
    nxt_state = state_ff;
    nxt_wait_cnt = wait_cnt_ff;
    case (state_ff)
      shrp_pkg::SHRP_ST_IDLE: begin
        if (wr_kind != shrp_pkg::SHRP_ACC_NONE) begin
          nxt_state = shrp_pkg::SHRP_ST_BUSY;
          // pcm space needs the longer interval
          nxt_wait_cnt = cap_addr_ff[2] ? `SHRP_PCM_WAIT_CYC : `SHRP_FM_WAIT_CYC;
        end
      end
      shrp_pkg::SHRP_ST_BUSY: begin
        if (wait_cnt_ff == 7'h01) begin
          nxt_state = shrp_pkg::SHRP_ST_IDLE; // clears itself
          nxt_wait_cnt = 7'h00;
        end else begin
          nxt_wait_cnt = wait_cnt_ff - 7'h01;
        end
      end
      default: begin
        nxt_state = shrp_pkg::SHRP_ST_IDLE;
        nxt_wait_cnt = 7'h00;
      end
    endcase
  end
  // interval registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= shrp_pkg::SHRP_ST_IDLE;
      wait_cnt_ff <= 7'h00;
    end else begin
      state_ff <= nxt_state;
      wait_cnt_ff <= nxt_wait_cnt;
    end
  end
  // ==========================================================
  // status byte assembly
  always_comb begin
    status_byte = `SHRP_BYTE_RST;
    status_byte[`SHRP_ST_IRQ_BIT] = irq_flag;
    status_byte[`SHRP_ST_T1_BIT] = timer_one_flag;
    status_byte[`SHRP_ST_T2_BIT] = timer_two_flag;
    status_byte[`SHRP_ST_LD_BIT] = ext_en_ff && header_loading_flag;
    status_byte[`SHRP_ST_BUSY_BIT] = ext_en_ff && (state_ff == shrp_pkg::SHRP_ST_BUSY);
  end
  // read cycle decode; of the fm addresses only zero (status) drives the bus
  assign rd_status = !cs_n && !rd_n && wr_n && !pcm_space_select && !fm_array_select
                     && !host_addr_bit0;
  assign rd_pcm = !cs_n && !rd_n && wr_n && ext_en_ff && pcm_space_select && !fm_array_select
                  && host_addr_bit0;
  // ==========================================================
  // host data bus drive
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_out_ff <= `SHRP_BYTE_RST;
      data_oe_ff <= 1'b0;
    end else begin
      data_oe_ff <= rd_status || rd_pcm; // released when deselected
      if (rd_pcm) begin
        data_out_ff <= pcm_rd_data;
      end else if (rd_status) begin
        data_out_ff <= status_byte;
      end else begin
        data_out_ff <= `SHRP_BYTE_RST;
      end
    end
  end
  // ==========================================================
  // outputs, all from flops
  assign data_out = data_out_ff;
  assign data_oe = data_oe_ff;
  assign fm_wr_stb = fm_stb_ff;
  assign fm_wr_array = fm_array_ff;
  assign fm_wr_index = fm_index_ff;
  assign fm_wr_data = fm_data_ff;
  assign pcm_wr_stb = pcm_stb_ff;
  assign pcm_wr_index = pcm_index_ff;
  assign pcm_wr_data = pcm_data_ff;
  assign extension_enable_bit = ext_en_ff;
  assign write_busy = (state_ff == shrp_pkg::SHRP_ST_BUSY);
  assign half_rate_clock_out = clk_div_ff;
endmodule

/* File: shrp_host_port_chk.sv */
`timescale 1ns/1ps
`include "shrp_cfg.svh"

// ==========================================================
// port checker for the host register port
module shrp_chk (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // host side
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic host_addr_bit0,
  input wire logic fm_array_select,
  input wire logic pcm_space_select,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  // core flags
  input wire logic irq_flag,
  input wire logic timer_one_flag,
  input wire logic timer_two_flag,
  input wire logic header_loading_flag,
  // core writes
  input wire logic fm_wr_stb,
  input wire logic fm_wr_array,
  input wire logic [7:0] fm_wr_index,
  input wire logic [7:0] fm_wr_data,
  input wire logic pcm_wr_stb,
  input wire logic [7:0] pcm_wr_index,
  input wire logic [7:0] pcm_wr_data,
  // mode and timing
  input wire logic extension_enable_bit,
  input wire logic write_busy,
  input wire logic half_rate_clock_out
);
  logic [6:0] busy_len_ff;
  logic [2:0] run_ff;
  logic [2:0] ac;

  // address bits as one code
  assign ac = {pcm_space_select, fm_array_select, host_addr_bit0};

  // busy length and cycles since reset release
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      busy_len_ff <= 7'h00;
      run_ff <= 3'h0;
    end else begin
      busy_len_ff <= write_busy ? busy_len_ff + 7'h01 : 7'h00;
      run_ff <= (run_ff == 3'h4) ? run_ff : run_ff + 3'h1;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_bus_released: assert property ($past(cs_n) |-> !data_oe)
    else $error("bus driven while deselected");
  a_status_read: assert property (!cs_n && !rd_n && wr_n && ac == 3'h0 |=> data_oe &&
    data_out[7:2] == {$past({irq_flag, timer_one_flag, timer_two_flag}), 3'h0})
    else $error("status byte wrong");
  a_flags_gated: assert property (!$past(extension_enable_bit) && data_oe && $past(ac) == 3'h0
    |-> data_out[1:0] == 2'h0) else $error("busy or load shown while gated");
  a_read_addr: assert property (data_oe |-> $past(ac) == 3'h0 || $past(ac) == 3'h5)
    else $error("bus driven for unreadable address");
  a_pcm_read_lock: assert property ($past(ac) == 3'h5 && !$past(extension_enable_bit) |-> !data_oe)
    else $error("pcm read while locked");
  a_pcm_write_lock: assert property (pcm_wr_stb |-> extension_enable_bit)
    else $error("pcm write while locked");
  a_fm_pulse: assert property (fm_wr_stb |=> !fm_wr_stb)
    else $error("fm strobe too long");
  a_pcm_pulse: assert property (pcm_wr_stb |=> !pcm_wr_stb)
    else $error("pcm strobe too long");
  a_busy_start: assert property (fm_wr_stb || pcm_wr_stb |-> write_busy)
    else $error("write without busy interval");
  a_busy_len: assert property ($fell(write_busy) |-> busy_len_ff == `SHRP_FM_WAIT_CYC ||
    busy_len_ff == `SHRP_PCM_WAIT_CYC) else $error("busy interval length wrong");
  a_half_clock: assert property (run_ff == 3'h4 |-> half_rate_clock_out != $past(half_rate_clock_out))
    else $error("half rate clock stalled");

  c_pcm_write: cover property (pcm_wr_stb);
  c_busy_end: cover property ($fell(write_busy));
  c_busy_seen: cover property (data_oe && data_out[0]);
endmodule

bind shrp_host_port shrp_chk chk_u (.*);

/* File: shrp_pcm_regs.sv */
`timescale 1ns/1ps

// ==========================================================
// pcm and mixing register store, registered read data
module shrp_pcm_regs #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  // read port
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);

  logic [DW-1:0] mem [0:(1<<AW)-1]; // register array, not reset
  logic [DW-1:0] rd_data_ff; // read data register

  // store host writes
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read data comes out of a flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_ff <= '0;
    end else begin
      rd_data_ff <= mem[rd_addr];
    end
  end

  assign rd_data = rd_data_ff;

endmodule

/* File: shrp_pkg.sv */
package shrp_pkg;

  // decoded kind of host cycle
  typedef enum logic [2:0] {
    SHRP_ACC_NONE,
    SHRP_ACC_FM_ADDR,
    SHRP_ACC_FM_DATA,
    SHRP_ACC_PCM_ADDR,
    SHRP_ACC_PCM_DATA
  } shrp_acc_t;

  // write interval state
  typedef enum logic {
    SHRP_ST_IDLE,
    SHRP_ST_BUSY
  } shrp_state_t;

endpackage

/* File: synth_host_register_port_bench.sv */
`timescale 1ns/1ps
`include "shrp_cfg.svh"

// ==========================================================
// self-checking bench for the host register port
module synth_host_register_port_bench;
  localparam int FMW = `SHRP_FM_WAIT_CYC;
  localparam int PCMW = `SHRP_PCM_WAIT_CYC;
  logic ref_clk, rstn, cs_n, rd_n, wr_n, data_oe;
  logic host_addr_bit0, fm_array_select, pcm_space_select;
  logic [7:0] data_in, data_out, fm_wr_index, fm_wr_data, pcm_wr_index, pcm_wr_data;
  logic fm_wr_stb, fm_wr_array, pcm_wr_stb, extension_enable_bit, write_busy, half_rate_clock_out;
  logic irq_flag, timer_one_flag, timer_two_flag, header_loading_flag;
  logic [7:0] rv;
  logic oe;
  int errors = 0, cmp_count = 0, cycles = 0, fm_n = 0, pcm_n = 0;

  shrp_host_port dut_u (.*);
  shrp_host_model host_u (.*);

  // clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // strobe counters and hang limit
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (fm_wr_stb === 1'b1) fm_n <= fm_n + 1;
    if (pcm_wr_stb === 1'b1) pcm_n <= pcm_n + 1;
    if (cycles == 5000) begin
      errors = errors + 1;
      finish_test();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // every address but status and pcm data leaves the bus alone
  task automatic quiet(input logic pcm_on);
    for (int i = 1; i < 8; i++) begin
      if (!(pcm_on && i == 5)) begin
        host_u.rd(3'(i), rv, oe);
        chk({7'h00, oe}, 8'h00);
      end
    end
  endtask

  task automatic finish_test();
    if (errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    rstn = 1'b0;
    {irq_flag, timer_one_flag, timer_two_flag, header_loading_flag} = 4'h0;
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    host_u.rd(3'h0, rv, oe);
    chk(rv, 8'h00);
    irq_flag <= 1'b1;
    timer_two_flag <= 1'b1;
    header_loading_flag <= 1'b1;
    host_u.rd(3'h0, rv, oe);
    chk(rv, 8'hA0);
    quiet(1'b0);
    host_u.wr(3'h4, 8'h20, PCMW);
    host_u.wr(3'h5, 8'h77, PCMW);
    chk(8'(pcm_n), 8'h00);
    // busy and loading stay hidden while the extension is off
    host_u.wr(3'h0, 8'h20, 0);
    host_u.rd(3'h0, rv, oe);
    chk(rv, 8'hA0);
    repeat (FMW) @(posedge ref_clk);
    host_u.wr(3'h1, 8'h3C, FMW);
    chk({fm_wr_array, 7'(fm_n)}, 8'h01);
    chk(fm_wr_index, 8'h20);
    chk(fm_wr_data, 8'h3C);
    host_u.wr(3'h2, `SHRP_EXT_EN_INDEX, FMW);
    host_u.wr(3'h3, 8'h01, FMW);
    chk({fm_wr_array, extension_enable_bit, fm_wr_index[5:0]}, 8'hC5);
    host_u.wr(3'h0, 8'h40, 0);
    host_u.rd(3'h0, rv, oe);
    chk(rv, 8'hA3);
    repeat (FMW) @(posedge ref_clk);
    host_u.rd(3'h0, rv, oe);
    chk(rv, 8'hA2);
    // pcm indexes stay clear of the memory registers with their own waits
    for (int i = 0; i < 2; i++) begin
      host_u.wr(3'h4, 8'h20 + 8'(i), PCMW);
      host_u.wr(3'h5, 8'h77 + 8'(i), PCMW);
      chk(pcm_wr_index, 8'h20 + 8'(i));
      chk(pcm_wr_data, 8'h77 + 8'(i));
    end
    chk(8'(pcm_n), 8'h02);
    for (int i = 1; i >= 0; i--) begin
      host_u.wr(3'h4, 8'h20 + 8'(i), PCMW);
      host_u.rd(3'h5, rv, oe);
      chk(rv, 8'h77 + 8'(i));
    end
    timer_one_flag <= 1'b1;
    host_u.rd(3'h0, rv, oe);
    chk(rv, 8'hE2);
    quiet(1'b1);
    finish_test();
  end
endmodule
